// File: sdram_guard_pkg.sv
package sdram_guard_pkg;
  // clock and array geometry
  localparam int CLK_PS = 5000; // 200 MHz system clock period in ps
  localparam int ROWS = 8192; // rows refreshed per retention period
  localparam int BANK_W = 2;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int DQ_W = 8;
  localparam int ADDR_W = 13;
  localparam int AP_BIT = 10; // auto-precharge / all-banks address bit
  localparam int CAS_LAT = 3; // read latency programmed into the mode word
  localparam int GAP_W = 8; // width of every gap timer

  // command gaps in ns, fastest grade
  localparam int T_RC_NS = 60;
  localparam int T_RFC_NS = 60;
  localparam int T_RAS_NS = 45;
  localparam int T_RP_NS = 15;
  localparam int T_RCD_NS = 15;
  localparam int T_RRD_NS = 10;
  localparam int T_DPL_NS = 12;
  localparam int T_DAL_NS = 25;
  localparam int T_MRD_NS = 10;
  localparam int T_XSR_NS = 65;
  localparam int T_PDE_NS = 5;
  localparam int T_INIT_NS = 100000; // power-up quiet time, 100 us
  localparam int MIN_GAP_CYC = 2; // cycle floor on some gaps
  localparam int RETAIN_NORMAL_MS = 64;
  localparam int RETAIN_HOT_MS = 32;
  localparam int RETAIN_HOTTEST_MS = 8;

  // ns to cycles: round up, apply floor
  function automatic int cyc(input int ns, input int minCyc);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS; // [RL17]
    if (c < minCyc) c = minCyc; // [RL17]
    if (c < 1) c = 1;
    return c;
  endfunction : cyc

  // refresh spacing: retention over rows, rounded down
  function automatic int refi(input int ms);
    return (ms * 1000000 / ROWS) * 1000 / CLK_PS;
  endfunction : refi

  localparam int RC_CYC = cyc(T_RC_NS, 1);
  localparam int RFC_CYC = cyc(T_RFC_NS, 1);
  localparam int RAS_CYC = cyc(T_RAS_NS, 1);
  localparam int RP_CYC = cyc(T_RP_NS, 1);
  localparam int RCD_CYC = cyc(T_RCD_NS, 1);
  localparam int RRD_CYC = cyc(T_RRD_NS, MIN_GAP_CYC); // [RL9]
  localparam int MRD_CYC = cyc(T_MRD_NS, MIN_GAP_CYC);
  localparam int DPL_CYC = cyc(T_DPL_NS, MIN_GAP_CYC);
  localparam int DAL_CYC = cyc(T_DAL_NS, 1);
  localparam int XSR_CYC = cyc(T_XSR_NS, 1);
  localparam int PDE_CYC = cyc(T_PDE_NS, 1);
  localparam int INIT_CYC = cyc(T_INIT_NS, 1);
  localparam logic [15:0] REFI_NORMAL = 16'(refi(RETAIN_NORMAL_MS));
  localparam logic [15:0] REFI_HOT = 16'(refi(RETAIN_HOT_MS));
  localparam logic [15:0] REFI_HOTTEST = 16'(refi(RETAIN_HOTTEST_MS));

  // gap timer indices and lengths
  localparam int G_RC = 0;
  localparam int G_RFC = 1;
  localparam int G_RAS = 2;
  localparam int G_RP = 3;
  localparam int G_RCD = 4;
  localparam int G_RRD = 5;
  localparam int G_MRD = 6;
  localparam int G_DPL = 7;
  localparam int G_DAL = 8;
  localparam int G_XSR = 9;
  localparam int G_PDE = 10;
  localparam int NUM_GAPS = 11;
  localparam logic [GAP_W-1:0] GAP_CYC [NUM_GAPS] = '{8'(RC_CYC), 8'(RFC_CYC), 8'(RAS_CYC),
    8'(RP_CYC), 8'(RCD_CYC), 8'(RRD_CYC), 8'(MRD_CYC), 8'(DPL_CYC), 8'(DAL_CYC),
    8'(XSR_CYC), 8'(PDE_CYC)};

  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  // burst of one, sequential, latency three, burst writes
  localparam logic [ADDR_W-1:0] MODE_WORD = 13'h0030;

  // temperature range codes
  localparam logic [1:0] TEMP_NORMAL = 2'h0; // up to 85 C
  localparam logic [1:0] TEMP_HOT = 2'h1; // above 85 C

  typedef enum logic [3:0] {
    ST_POWERUP = 4'h0, ST_PREALL = 4'h1, ST_INITREF = 4'h2, ST_LOADMODE = 4'h3,
    ST_IDLE = 4'h4, ST_REFRESH = 4'h5, ST_ACTIVATE = 4'h6, ST_ACCESS = 4'h7,
    ST_CLOSE = 4'h8, ST_SELFREF = 4'h9, ST_PDOWN = 4'ha
  } state_e;
endpackage : sdram_guard_pkg

// File: gap_timer.sv
`timescale 1ns/100ps
module gap_timer #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [W-1:0] loadValue,
  output logic done
);
  logic [W-1:0] count_q; // cycles still to wait after the command on the pins

  // load on the deciding edge, count down to zero
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= loadValue - W'(1);
    end else if (count_q != '0) begin
      count_q <= count_q - W'(1);
    end
  end

  // gap satisfied once the count is spent
  assign done = (count_q == '0);
endmodule : gap_timer

// File: sdram_timing_host.sv
// Contract
// RL1 - 60 ns after activate or refresh
// RL2 - row open 45 ns, closed well before limit
// RL3 - precharge to activate at least 15 ns
// RL4 - activate to read or write 15 ns
// RL5 - activates to other banks 10 ns apart
// RL6 - last write data to precharge 12 ns
// RL7 - auto-precharge write to activate 25 ns
// RL8 - mode load to next command 10 ns
// RL9 - those three gaps span two cycles minimum
// RL10 - self-refresh exit to activate 65 ns
// RL11 - clock enable up before next command
// RL12 - every row refreshed within retention period
// RL13 - initialise before any memory operation
// RL14 - no self-refresh above 85 C
// RL15 - memory samples all inputs on rising edge
// RL16 - quiet 100 us, precharge, two refreshes, mode
// RL17 - round ns up, apply cycle floor
// RL18 - evenly spaced refreshes per temperature range
`timescale 1ns/100ps
module sdram_timing_host #(
  parameter int INIT_CYCLES = sdram_guard_pkg::INIT_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [sdram_guard_pkg::BANK_W-1:0] reqBank,
  input wire logic [sdram_guard_pkg::ROW_W-1:0] reqRow,
  input wire logic [sdram_guard_pkg::COL_W-1:0] reqCol,
  input wire logic [sdram_guard_pkg::DQ_W-1:0] reqWdata,
  output logic reqReady,
  output logic rdValid,
  output logic [sdram_guard_pkg::DQ_W-1:0] rdData,
  input wire logic [1:0] tempRange,
  input wire logic selfRefreshReq,
  input wire logic powerDownReq,
  output logic initDone,
  output logic sdCke,
  output logic sdCsN,
  output logic sdRasN,
  output logic sdCasN,
  output logic sdWeN,
  output logic [sdram_guard_pkg::BANK_W-1:0] sdBa,
  output logic [sdram_guard_pkg::ADDR_W-1:0] sdAddr,
  output logic [sdram_guard_pkg::DQ_W-1:0] sdDqOut,
  output logic sdDqOe,
  input wire logic [sdram_guard_pkg::DQ_W-1:0] sdDqIn
);
  import sdram_guard_pkg::*;

  state_e state_q; // sequencer state
  state_e state_d;
  logic [3:0] cmd_d; // command presented next cycle
  logic [ADDR_W-1:0] addr_d;
  logic [BANK_W-1:0] ba_d;
  logic cke_d;
  logic [NUM_GAPS-1:0] gapLoad; // restart a gap timer
  logic [NUM_GAPS-1:0] gapDone; // gap timer has run out
  logic [15:0] initCnt_q; // power-up quiet counter
  logic initRef_q; // first init refresh already issued
  logic [15:0] refiCnt_q; // cycles to next refresh due
  logic refreshDue_q; // a refresh is owed
  logic refFire; // refresh or self-refresh entry issued
  logic actFire; // activate issued, request taken
  logic rdFire; // read issued
  logic wrFire; // write issued
  logic reqWrite_q; // latched request
  logic [BANK_W-1:0] reqBank_q;
  logic [COL_W-1:0] reqCol_q;
  logic [DQ_W-1:0] reqWdata_q;
  logic [CAS_LAT:0] rdPipe_q; // read return delay line
  logic commonOk; // gaps that guard every command
  logic actOk;
  logic refOk;

  // one timer per command gap
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GAPS; gi++) begin : g_gap
      gap_timer #(.W(GAP_W)) u_gap (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(gapLoad[gi]),
        .loadValue(GAP_CYC[gi]),
        .done(gapDone[gi])
      );
    end
  endgenerate

  // gates per command kind
  assign commonOk = gapDone[G_RFC] & gapDone[G_MRD] & gapDone[G_PDE]; // [RL1] [RL8] [RL11]
  assign actOk = commonOk & gapDone[G_RC] & gapDone[G_RP] & gapDone[G_RRD] // [RL1] [RL3] [RL5]
    & gapDone[G_DAL] & gapDone[G_XSR]; // [RL7] [RL10]
  assign refOk = commonOk & gapDone[G_RC] & gapDone[G_RP] & gapDone[G_DAL]; // [RL1] [RL7]

  // next command, pin values and state
  always_comb begin
    state_d = state_q;
    cmd_d = CMD_NOP;
    addr_d = '0;
    ba_d = reqBank_q;
    cke_d = sdCke;
    gapLoad = '0;
    refFire = 1'b0;
    actFire = 1'b0;
    rdFire = 1'b0;
    wrFire = 1'b0;
    case (state_q)
      ST_POWERUP: begin
        // only no-operation until the quiet time is over
        if (initCnt_q >= 16'(INIT_CYCLES - 1)) begin // [RL16]
          state_d = ST_PREALL;
        end
      end
      ST_PREALL: begin
        // precharge every bank
        if (commonOk) begin // [RL16]
          cmd_d = CMD_PRE;
          addr_d[AP_BIT] = 1'b1;
          gapLoad[G_RP] = 1'b1;
          state_d = ST_INITREF;
        end
      end
      ST_INITREF: begin
        // two refreshes before the mode load
        if (refOk) begin // [RL16]
          cmd_d = CMD_REF;
          refFire = 1'b1;
          gapLoad[G_RC] = 1'b1;
          gapLoad[G_RFC] = 1'b1;
          if (initRef_q) state_d = ST_LOADMODE;
        end
      end
      ST_LOADMODE: begin
        // program the mode word, then normal service
        if (commonOk && gapDone[G_RP] && gapDone[G_RC]) begin // [RL16]
          cmd_d = CMD_MRS;
          addr_d = MODE_WORD;
          gapLoad[G_MRD] = 1'b1; // [RL8]
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // refresh first, then traffic, then low power
        if (refreshDue_q) begin
          state_d = ST_REFRESH; // [RL12]
        end else if (reqValid) begin
          state_d = ST_ACTIVATE;
        end else if (selfRefreshReq && tempRange == TEMP_NORMAL && refOk) begin // [RL14]
          cmd_d = CMD_REF;
          cke_d = 1'b0;
          refFire = 1'b1;
          gapLoad[G_RC] = 1'b1; // [RL1]
          gapLoad[G_RFC] = 1'b1; // [RL1]
          state_d = ST_SELFREF;
        end else if (powerDownReq && commonOk) begin
          cke_d = 1'b0;
          state_d = ST_PDOWN;
        end
      end
      ST_REFRESH: begin
        if (refOk) begin // [RL1]
          cmd_d = CMD_REF;
          refFire = 1'b1;
          gapLoad[G_RC] = 1'b1;
          gapLoad[G_RFC] = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_ACTIVATE: begin
        // open the row of the waiting request
        if (actOk) begin // [RL13]
          cmd_d = CMD_ACT;
          ba_d = reqBank;
          addr_d = reqRow;
          actFire = 1'b1;
          gapLoad[G_RC] = 1'b1;
          gapLoad[G_RAS] = 1'b1;
          gapLoad[G_RCD] = 1'b1;
          gapLoad[G_RRD] = 1'b1;
          state_d = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (commonOk && gapDone[G_RCD]) begin // [RL4]
          addr_d = ADDR_W'(reqCol_q);
          if (reqWrite_q) begin
            // write closes its own row
            cmd_d = CMD_WRITE;
            addr_d[AP_BIT] = 1'b1;
            wrFire = 1'b1;
            gapLoad[G_DAL] = 1'b1; // [RL7]
            gapLoad[G_DPL] = 1'b1; // [RL6]
            state_d = ST_IDLE;
          end else begin
            cmd_d = CMD_READ;
            rdFire = 1'b1;
            state_d = ST_CLOSE;
          end
        end
      end
      ST_CLOSE: begin
        // close the row once it has been open long enough
        if (commonOk && gapDone[G_RAS] && gapDone[G_DPL]) begin // [RL2] [RL6]
          cmd_d = CMD_PRE;
          gapLoad[G_RP] = 1'b1; // [RL3]
          state_d = ST_IDLE;
        end
      end
      ST_SELFREF: begin
        if (!selfRefreshReq) begin
          cke_d = 1'b1;
          gapLoad[G_XSR] = 1'b1; // [RL10]
          state_d = ST_IDLE;
        end
      end
      ST_PDOWN: begin
        // leave early when a refresh falls due
        if (!powerDownReq || refreshDue_q) begin
          cke_d = 1'b1;
          gapLoad[G_PDE] = 1'b1; // [RL11]
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // sequencer state
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= ST_POWERUP;
    end else begin
      state_q <= state_d;
    end
  end

  // memory pins, all registered
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sdCke <= 1'b1;
      {sdCsN, sdRasN, sdCasN, sdWeN} <= CMD_NOP;
      sdBa <= '0;
      sdAddr <= '0;
      sdDqOut <= '0;
      sdDqOe <= 1'b0;
    end else begin
      sdCke <= cke_d;
      {sdCsN, sdRasN, sdCasN, sdWeN} <= cmd_d;
      sdBa <= ba_d;
      sdAddr <= addr_d;
      sdDqOut <= reqWdata_q;
      sdDqOe <= wrFire; // data rides with the write command
    end
  end

  // power-up count and init progress
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      initCnt_q <= '0;
      initRef_q <= 1'b0;
      initDone <= 1'b0;
    end else begin
      if (state_q == ST_POWERUP) initCnt_q <= initCnt_q + 16'd1;
      if (state_q == ST_INITREF && refFire) initRef_q <= 1'b1;
      if (state_q == ST_LOADMODE && state_d == ST_IDLE) initDone <= 1'b1; // [RL13]
    end
  end

  // evenly spaced refresh demand per temperature range
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      refiCnt_q <= REFI_NORMAL;
      refreshDue_q <= 1'b0;
    end else if (!initDone || state_q == ST_SELFREF) begin
      refiCnt_q <= REFI_HOTTEST; // no demand before init; memory refreshes itself in self-refresh
      refreshDue_q <= 1'b0;
    end else if (refiCnt_q == '0) begin
      refiCnt_q <= (tempRange == TEMP_NORMAL) ? REFI_NORMAL : // [RL18]
        (tempRange == TEMP_HOT) ? REFI_HOT : REFI_HOTTEST; // [RL12]
      refreshDue_q <= 1'b1; // set wins over a same-cycle clear
    end else begin
      refiCnt_q <= refiCnt_q - 16'd1;
      if (refFire) refreshDue_q <= 1'b0;
    end
  end

  // request capture and hand-shake
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reqReady <= 1'b0;
      reqWrite_q <= 1'b0;
      reqBank_q <= '0;
      reqCol_q <= '0;
      reqWdata_q <= '0;
    end else begin
      reqReady <= actFire;
      if (actFire) begin
        reqWrite_q <= reqWrite;
        reqBank_q <= reqBank;
        reqCol_q <= reqCol;
        reqWdata_q <= reqWdata;
      end
    end
  end

  // read data one latency after the read
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rdPipe_q <= '0;
      rdValid <= 1'b0;
      rdData <= '0;
    end else begin
      rdPipe_q <= {rdPipe_q[CAS_LAT-1:0], rdFire};
      rdValid <= rdPipe_q[CAS_LAT];
      if (rdPipe_q[CAS_LAT]) rdData <= sdDqIn;
    end
  end

  // cycles since activate, refresh, self-refresh exit
  logic [3:0] pinCmd;
  logic inSref_q;
  logic ckeLast_q;
  logic [2:0] evt;
  logic [7:0] since_q [3];
  assign pinCmd = {sdCsN, sdRasN, sdCasN, sdWeN};
  assign evt = {sdCke && !ckeLast_q && inSref_q, pinCmd == CMD_REF, pinCmd == CMD_ACT};

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      inSref_q <= 1'b0;
      ckeLast_q <= 1'b1;
      for (int i = 0; i < 3; i++) since_q[i] <= 8'hff;
    end else begin
      ckeLast_q <= sdCke;
      if (pinCmd == CMD_REF && !sdCke) inSref_q <= 1'b1;
      else if (sdCke) inSref_q <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        if (evt[i]) since_q[i] <= 8'd1;
        else if (since_q[i] != 8'hff) since_q[i] <= since_q[i] + 8'd1;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence seqWriteAp;
    pinCmd == CMD_WRITE && sdAddr[AP_BIT];
  endsequence
  sequence seqNoOpenOrRef;
    (pinCmd != CMD_ACT && pinCmd != CMD_REF) [*4];
  endsequence

  chk_refresh_spacing: assert property ((pinCmd != CMD_NOP) |-> since_q[1] >= 8'(RFC_CYC) // [RL1]
    && (pinCmd != CMD_ACT || since_q[0] >= 8'(RC_CYC))) else $error("refresh/activate gap");
  chk_row_open: assert property ((pinCmd == CMD_PRE && !sdAddr[AP_BIT]) |-> // [RL2]
    since_q[0] >= 8'(RAS_CYC) && since_q[0] != 8'hff) else $error("row open time");
  chk_pre_to_act: assert property ((pinCmd == CMD_PRE) |=> (pinCmd != CMD_ACT) [*2]) // [RL3]
    else $error("precharge to activate too soon");
  chk_act_to_access: assert property ((pinCmd == CMD_ACT) |=> // [RL4]
    (pinCmd != CMD_READ && pinCmd != CMD_WRITE) [*2]) else $error("activate to access");
  chk_act_to_act: assert property ((pinCmd == CMD_ACT) |=> pinCmd != CMD_ACT) // [RL5] [RL9]
    else $error("activates too close");
  chk_write_recovery: assert property (seqWriteAp |=> seqNoOpenOrRef) // [RL6] [RL7]
    else $error("write recovery too short");
  chk_mode_gap: assert property ((pinCmd == CMD_MRS) |=> pinCmd == CMD_NOP) // [RL8] [RL9]
    else $error("command too soon after mode load");
  chk_sref_exit: assert property ((pinCmd == CMD_ACT) |-> since_q[2] >= 8'(XSR_CYC)) // [RL10]
    else $error("activate too soon after self-refresh");
  chk_cke_setup: assert property ($rose(sdCke) |-> pinCmd == CMD_NOP) // [RL11]
    else $error("command with clock enable rising");
  chk_init_first: assert property ((pinCmd == CMD_ACT || pinCmd == CMD_READ // [RL13] [RL16]
    || pinCmd == CMD_WRITE) |-> initDone) else $error("access before init");
  chk_sref_temp: assert property ((pinCmd == CMD_REF && !sdCke) |-> // [RL14]
    $past(tempRange) == TEMP_NORMAL) else $error("self-refresh when hot");
  chk_refresh_owed: assert property ($rose(refreshDue_q) && state_q == ST_IDLE // [RL12] [RL18]
    |-> ##[1:40] pinCmd == CMD_REF) else $error("refresh not issued");
endmodule : sdram_timing_host

// File: sdram_device_model.sv
`timescale 1ns/100ps
module sdram_device_model #(
  parameter int INIT_CYCLES = 50
) (
  input wire logic sys_clk,
  input wire logic sdCke,
  input wire logic sdCsN,
  input wire logic sdRasN,
  input wire logic sdCasN,
  input wire logic sdWeN,
  input wire logic [sdram_guard_pkg::BANK_W-1:0] sdBa,
  input wire logic [sdram_guard_pkg::ADDR_W-1:0] sdAddr,
  input wire logic [sdram_guard_pkg::DQ_W-1:0] sdDqOut,
  input wire logic sdDqOe,
  input wire logic [1:0] tempRange,
  output logic [sdram_guard_pkg::DQ_W-1:0] sdDqIn,
  output logic [15:0] faults,
  output logic [15:0] refCount
);
  import sdram_guard_pkg::*;
  localparam int PAST = -100000; // every gap starts long satisfied
  logic [3:0] cmd; // active-low command word
  int cyc = 0, nopRun = 0, initRefs = 0, limQ = 0, key = 0, pendAt = 0, lastDue = 0;
  int lastAct[4] = '{4{PAST}}, lastPre[4] = '{4{PAST}}, lastWrB[4] = '{4{PAST}};
  int lastActAny = PAST, lastRef = PAST, lastMrs = PAST, lastWr = PAST, lastExit = PAST;
  logic [ROW_W-1:0] openRow[4] = '{4{13'h0000}}; // row held open per bank
  logic isOpen[4] = '{4{1'b0}};
  logic ready = 1'b0, preSeen = 1'b0, ckePrev = 1'b1, inSelf = 1'b0, pend = 1'b0;
  logic [DQ_W-1:0] pendData = '0; // byte due on the data pins
  logic [DQ_W-1:0] store[int]; // sparse array contents
  assign cmd = {sdCsN, sdRasN, sdCasN, sdWeN};
  // widest refresh spacing allowed in a temperature range
  function automatic int refLim(input logic [1:0] t);
    return (t == TEMP_NORMAL) ? REFI_NORMAL : (t == TEMP_HOT) ? REFI_HOT : REFI_HOTTEST;
  endfunction : refLim
  // count one broken spacing
  task automatic gap(input int since, input int need);
    if (cyc - since < need) faults++;
  endtask : gap
  // data and counters idle at start
  initial begin
    sdDqIn = 8'h00;
    faults = 16'h0;
    refCount = 16'h0;
  end
  // all pins registered on the rising edge
  always @(posedge sys_clk) begin
    cyc++;
    if (limQ < refLim(tempRange)) limQ = refLim(tempRange);
    // refresh must not lag the retention budget
    if (ready && !inSelf && cyc - lastDue > limQ + 40) begin
      faults++;
      lastDue = cyc;
    end
    // a command right at the clock-enable rise is too early
    if (!ckePrev && sdCke && cmd != CMD_NOP) faults++;
    if (!sdCke && ckePrev && cmd == CMD_REF) begin
      inSelf = 1'b1;
      if (tempRange != TEMP_NORMAL) faults++;
    end else if (inSelf && sdCke) begin
      inSelf = 1'b0;
      lastExit = cyc;
      lastDue = cyc;
    end else if (sdCke && ckePrev) begin
      if (cmd != CMD_NOP) begin
        gap(lastMrs, MRD_CYC);
        gap(lastRef, RFC_CYC);
      end
      case (cmd)
        CMD_NOP: if (!preSeen) nopRun++;
        CMD_PRE: begin
          if (!ready && (nopRun < INIT_CYCLES || !sdAddr[AP_BIT])) faults++;
          preSeen = 1'b1;
          for (int b = 0; b < 4; b++) begin
            if (sdAddr[AP_BIT] || sdBa == 2'(b)) begin
              if (isOpen[b]) begin
                gap(lastAct[b], RAS_CYC);
                gap(lastWrB[b], DPL_CYC);
                if (cyc - lastAct[b] > 100000 * 1000 / CLK_PS) faults++;
              end
              isOpen[b] = 1'b0;
              lastPre[b] = cyc;
            end
          end
        end
        CMD_ACT: begin
          if (!ready || isOpen[sdBa]) faults++;
          gap(lastAct[sdBa], RC_CYC);
          gap(lastActAny, RRD_CYC);
          gap(lastPre[sdBa], RP_CYC);
          gap(lastWr, DAL_CYC);
          gap(lastExit, XSR_CYC);
          isOpen[sdBa] = 1'b1;
          openRow[sdBa] = sdAddr;
          lastAct[sdBa] = cyc;
          lastActAny = cyc;
        end
        CMD_READ, CMD_WRITE: begin
          if (!ready || !isOpen[sdBa]) faults++;
          gap(lastAct[sdBa], RCD_CYC);
          key = int'({sdBa, openRow[sdBa], sdAddr[COL_W-1:0]});
          if (cmd == CMD_WRITE) begin
            if (!sdDqOe) faults++;
            store[key] = sdDqOut;
            if (sdAddr[AP_BIT]) lastWr = cyc;
            else lastWrB[sdBa] = cyc;
          end else begin
            pend = 1'b1;
            pendAt = cyc + CAS_LAT;
            pendData = store.exists(key) ? store[key] : 8'(key) ^ 8'h5a;
          end
          if (sdAddr[AP_BIT]) isOpen[sdBa] = 1'b0;
        end
        CMD_REF: begin
          if (!preSeen || isOpen.or()) faults++;
          gap(lastWr, DAL_CYC);
          if (!ready) initRefs++;
          lastRef = cyc;
          lastDue = cyc;
          limQ = refLim(tempRange);
          refCount++;
        end
        CMD_MRS: begin
          if (!ready && initRefs < 2) faults++;
          ready = 1'b1;
          lastMrs = cyc;
          lastDue = cyc;
        end
        default: ;
      endcase
    end
    ckePrev = sdCke;
    // read byte shows one cycle before its sampling edge, otherwise churns
    if (pend && cyc == pendAt - 1) sdDqIn <= pendData;
    else sdDqIn <= ~sdDqIn;
    if (pend && cyc == pendAt) pend = 1'b0;
  end
endmodule : sdram_device_model

// File: sdram_command_timing_guard_tb_top.sv
`timescale 1ns/100ps
module sdram_command_timing_guard_tb_top;
  import sdram_guard_pkg::*;
  localparam int INIT_SIM = 50; // shortened power-up quiet time
  logic sys_clk, reset_n, reqValid, reqWrite, reqReady, rdValid, initDone;
  logic selfRefreshReq, powerDownReq, sdCke, sdCsN, sdRasN, sdCasN, sdWeN, sdDqOe;
  logic [1:0] reqBank, tempRange, sdBa;
  logic [12:0] reqRow, sdAddr;
  logic [9:0] reqCol;
  logic [7:0] reqWdata, rdData, sdDqOut, sdDqIn;
  logic [15:0] faults, refCount;
  int errCount, checked;
  sdram_timing_host #(.INIT_CYCLES(INIT_SIM)) dut (.sys_clk, .reset_n, .reqValid, .reqWrite,
    .reqBank, .reqRow, .reqCol, .reqWdata, .reqReady, .rdValid, .rdData, .tempRange,
    .selfRefreshReq, .powerDownReq, .initDone, .sdCke, .sdCsN, .sdRasN, .sdCasN, .sdWeN, .sdBa,
    .sdAddr, .sdDqOut, .sdDqOe, .sdDqIn);
  sdram_device_model #(.INIT_CYCLES(INIT_SIM)) devModel (.sys_clk, .sdCke, .sdCsN, .sdRasN,
    .sdCasN, .sdWeN, .sdBa, .sdAddr, .sdDqOut, .sdDqOe, .tempRange, .sdDqIn, .faults, .refCount);
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // counts, verdict, stop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // one request held until taken; reads wait for their byte
  task automatic access(input logic wr, input logic [1:0] b, input logic [12:0] r,
      input logic [9:0] c, input logic [7:0] d, output logic [7:0] q);
    int n;
    reqValid = 1'b1; reqWrite = wr; reqBank = b; reqRow = r; reqCol = c; reqWdata = d;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (reqReady !== 1'b1 && n < 3000);
    reqValid = 1'b0;
    check("reqReady", 16'(reqReady), 16'h1);
    q = 8'h00;
    if (!wr) begin
      n = 0;
      do begin @(negedge sys_clk); n++; end while (rdValid !== 1'b1 && n < 20);
      check("rdValid", 16'(rdValid), 16'h1);
      q = rdData;
    end
  endtask : access
  // wait for clock enable to reach a level
  task automatic waitCke(input logic lvl);
    while (sdCke !== lvl) @(negedge sys_clk);
  endtask : waitCke
  // reset state, then power-up order
  task automatic t_reset();
    int n;
    check("cke in reset", 16'(sdCke), 16'h1);
    check("cmd in reset", 16'({sdCsN, sdRasN, sdCasN, sdWeN}), 16'(CMD_NOP));
    check("flags in reset", 16'({sdDqOe, reqReady, rdValid, initDone}), 16'h0);
    reset_n = 1'b1;
    n = 0;
    while (initDone !== 1'b1 && n < 500) begin @(negedge sys_clk); n++; end
    check("initDone", 16'(initDone), 16'h1);
    check("init late", 16'(n > INIT_SIM), 16'h1);
    check("init refreshes", refCount, 16'h2);
    check("faults", faults, 16'h0);
    $display("test reset done");
  endtask : t_reset
  // back-to-back writes over all banks, reads in reverse
  task automatic t_rw();
    logic [7:0] q;
    logic [12:0] rows[4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
    for (int b = 0; b < 4; b++) access(1'b1, 2'(b), rows[b], ~10'(b), 8'(8'ha0 + b), q);
    for (int b = 3; b >= 0; b--) begin
      access(1'b0, 2'(b), rows[b], ~10'(b), 8'h00, q);
      check("rdData", 16'(q), 16'(8'ha0 + b));
    end
    access(1'b0, 2'h1, 13'h0000, 10'h000, 8'h00, q);
    check("fresh byte", 16'(q), 16'h5a);
    check("faults", faults, 16'h0);
    $display("test access done");
  endtask : t_rw
  // two refreshes per 2.5 intervals, every range
  task automatic t_refresh();
    int lim;
    logic [15:0] base;
    for (int t = 0; t < 4; t++) begin
      tempRange = 2'(t);
      lim = (t == 0) ? 1562 : (t == 1) ? 781 : 195;
      base = refCount;
      while (refCount === base) @(negedge sys_clk);
      base = refCount;
      repeat (lim * 5 / 2) @(negedge sys_clk);
      check("refresh count", refCount - base, 16'h2);
    end
    check("faults", faults, 16'h0);
    tempRange = TEMP_NORMAL;
    $display("test refresh done");
  endtask : t_refresh
  // refused when hot, entered when cool, then an access
  task automatic t_selfref();
    int low;
    logic [7:0] q;
    low = 0;
    tempRange = TEMP_HOT;
    selfRefreshReq = 1'b1;
    repeat (400) begin @(negedge sys_clk); if (sdCke !== 1'b1) low++; end
    check("hot entry", 16'(low), 16'h0);
    tempRange = TEMP_NORMAL;
    waitCke(1'b0);
    check("self entry", 16'(sdCke), 16'h0);
    repeat (50) @(negedge sys_clk);
    selfRefreshReq = 1'b0;
    access(1'b0, 2'h2, 13'h0aaa, 10'h3fd, 8'h00, q);
    check("rdData", 16'(q), 16'ha2);
    check("faults", faults, 16'h0);
    $display("test self refresh done");
  endtask : t_selfref
  // long power-down, refresh must still be kept
  task automatic t_pdown();
    logic [7:0] q;
    logic [15:0] base;
    powerDownReq = 1'b1;
    waitCke(1'b0);
    check("pd entry", 16'(sdCke), 16'h0);
    base = refCount;
    repeat (2000) @(negedge sys_clk);
    check("pd refresh", 16'(refCount != base), 16'h1);
    powerDownReq = 1'b0;
    access(1'b1, 2'h0, 13'h0042, 10'h001, 8'h7e, q);
    access(1'b0, 2'h0, 13'h0042, 10'h001, 8'h00, q);
    check("rdData", 16'(q), 16'h7e);
    check("faults", faults, 16'h0);
    $display("test power down done");
  endtask : t_pdown
  // main sequence
  initial begin
    errCount = 0; checked = 0;
    reset_n = 1'b0; reqValid = 1'b0; reqWrite = 1'b0; reqBank = 2'h0; reqRow = 13'h0;
    reqCol = 10'h0; reqWdata = 8'h00; tempRange = TEMP_NORMAL;
    selfRefreshReq = 1'b0; powerDownReq = 1'b0;
    repeat (5) @(negedge sys_clk);
    t_reset();
    t_rw();
    t_refresh();
    t_selfref();
    t_pdown();
    end_sim();
  end
  // watchdog well beyond the expected run
  initial begin
    #200000;
    errCount++;
    $display("watchdog expired");
    end_sim();
  end
endmodule : sdram_command_timing_guard_tb_top
